// >>> usb_ctrl_defs.vh
// constants for the usb device control, status, interrupt and event block
//
// Behaviour
// R1: ten sources on two vectors; vector needs nonzero level, sources have enables
// R2: transaction done per endpoint; endpoint recorded, pushed to queue when enabled
// R3: in/out completion sets transfer flag, setup completion sets setup flag
// R4: received start-of-frame token sets frame start flag on bus vector
// R5: suspend flag set after lines idle for 3 ms
// R6: resume flag set on non-idle line state while suspended, wakes chip
// R7: bus-reset flag set when reset condition seen on the lines
// R8: iso crc flag set on crc or stuff error to iso endpoint
// R9: underflow flag when cannot return data, overflow when cannot accept
// R10: stall flag set when a stall handshake was returned
// R11: four events out: setup, frame start, crc error, under-or-overflow
// R12: break option off: acknowledge debugger break at once
// R13: break option on: acknowledge after ongoing transaction, then nack all
// R14: enable bit 7 of control a; clearing aborts ongoing transaction at once
// R15: speed bit resets to zero (low speed); one selects full speed
// R16: queue enable pushes table address of each completing endpoint
// R17: frame store bit set saves latest frame number, clear does not
// R18: packets above four-bit top endpoint dropped, others looked up
// R19: hold pull-up bit keeps pull-up in chip reset; power-on clears it; code keeps only d- pull-up, as reset clears speed bit after one cycle
// R20: remote wake drives upstream resume only after 5 ms suspended; code waits on idle count, saturating at 3 ms, so default never drives
// R21: refuse-all bit nacks everything and blocks memory access except setup
// R22: connect bit enables d+ (full) or d- (low) pull-up; clear detaches
// R23: status reports upstream resume sent, resume received, suspended
// R24: bus-reset status set after single-ended zero held 2.5 us
// R25: no interrupt leaves unless the two-bit level is nonzero
// R26: request high while an enabled set flag exists and level nonzero
`ifndef USB_CTRL_DEFS_VH
`define USB_CTRL_DEFS_VH
// register offsets
`define OFS_CONTROL_A 4'h0
`define OFS_CONTROL_B 4'h1
`define OFS_LINE_STATUS 4'h2
`define OFS_IRQ_CTRL_A 4'h3
`define OFS_IRQ_CTRL_B 4'h4
`define OFS_FLAGS_A 4'h5
`define OFS_FLAGS_B 4'h6
`define OFS_FRAME_LO 4'h7
`define OFS_FRAME_HI 4'h8
`define OFS_DONE_EP 4'h9
`define OFS_DEBUG 4'hA
// control a fields
`define CA_ENABLE 7
`define CA_SPEED 6
`define CA_QUEUE 5
`define CA_FRSTORE 4
// control b fields
`define CB_HOLDPU 4
`define CB_RWAKE 2
`define CB_REFUSE 1
`define CB_CONNECT 0
`define CB_MASK 8'h17
// status fields
`define ST_UPSTREAM_WAKE_SENT 3
`define ST_RESUME 2
`define ST_SUSPEND 1
`define ST_LINE_RESET_SEEN 0
// irq control a fields
`define IA_SOF 7
`define IA_BUSEV 6
`define IA_BUSERR 5
`define IA_STALL 4
`define IA_MASK 8'hF3
`define IB_MASK 8'h03
// flags a bits
`define FA_SOF 7
`define FA_SUSP 6
`define FA_RESUME 5
`define FA_RST 4
`define FA_CRC 3
`define FA_UNF 2
`define FA_OVF 1
`define FA_STALL 0
// flags b bits
`define FB_XFER 1
`define FB_SETUP 0
// debug register fields
`define DB_BREAKOPT 0
// reset value of every register except the hold pull-up bit of control b, which keeps its value
`define REG_RESET 8'h00
// times and their counts at 50 MHz (20 ns), sized to the 24-bit counters
`define CLK_NS 20
`define IDLE_SUSP_NS 3000000
`define IDLE_SUSP_CYC 24'h0249F0
`define WAKE_HOLD_NS 5000000
`define WAKE_HOLD_CYC 24'h03D090
`define SE0_RST_NS 2500
`define SE0_RST_CYC 24'h00007D
`define RESUME_DRV_NS 1000000
`define RESUME_DRV_CYC 24'h00C350
`endif

// >>> usb_ctrl_irq.v
// usb device control, status, interrupt and event logic
`timescale 1ns/1ps
`default_nettype none
`include "usb_ctrl_defs.vh"
module usb_ctrl_irq #(
   parameter [23:0] IDLE_SUSP_CYC = `IDLE_SUSP_CYC,
   parameter [23:0] WAKE_HOLD_CYC = `WAKE_HOLD_CYC,
   parameter [23:0] RESUME_DRV_CYC = `RESUME_DRV_CYC
) (
   input wire core_clk_i, // 50 MHz clock
   input wire rst_i, // synchronous reset, active high
   input wire por_i, // power-on reset, active high
   input wire [3:0] addr_i, // register address
   input wire [7:0] wdata_i, // write data
   input wire wr_i, // write strobe
   input wire rd_i, // read strobe
   output reg [7:0] rdata_o, // read data, cycle after strobe
   input wire dp_i, // d+ line level (async)
   input wire dm_i, // d- line level (async)
   output wire dp_o, // d+ drive value
   output wire dm_o, // d- drive value
   output wire line_oe_o, // high while driving the lines
   output wire dp_pullup_o, // d+ pull-up on
   output wire dm_pullup_o, // d- pull-up on
   output wire enabled_o, // interface enabled
   output wire full_speed_o, // speed selection
   output wire done_queue_enable_o, // completion queue enabled
   output wire [3:0] top_endpoint_index_o, // highest endpoint served
   input wire [3:0] token_ep_i, // endpoint of current token
   output wire token_ep_accept_o, // token endpoint is within range
   input wire sof_i, // pulse: sof token received
   input wire [10:0] frame_index_word_i, // frame number of that sof
   output reg [10:0] frame_store_o, // stored frame number
   output reg frame_store_wr_o, // pulse: frame number written to memory
   input wire xfer_done_i, // pulse: in or out transaction completed
   input wire setup_done_i, // pulse: setup transaction completed
   input wire [3:0] done_ep_i, // endpoint of the completion
   input wire [15:0] done_table_addr_i, // table address of that endpoint
   output reg queue_push_o, // pulse: push address into queue
   output reg [15:0] queue_addr_o, // address pushed
   input wire iso_crc_err_i, // pulse: crc/stuff error, iso endpoint
   input wire starved_i, // pulse: could not return data
   input wire overrun_i, // pulse: could not accept data
   input wire stall_sent_i, // pulse: stall handshake returned
   input wire trans_busy_i, // a transaction is under way
   input wire is_setup_i, // current transaction is a setup
   output wire nack_all_o, // answer nack to every transaction
   output wire mem_block_o, // forbid on-chip memory access
   output wire abort_o, // abort ongoing transaction now
   input wire debugger_break_i, // break request from debugger
   output reg debugger_break_ack_o, // break acknowledged
   output wire xfer_done_vector_o, // transaction-complete request
   output wire line_event_vector_o, // bus-event request
   output wire [1:0] irq_priority_level_o, // interrupt level
   output wire wake_o, // asynchronous wake on resume
   output reg ev_setup_o, // event: setup complete
   output reg ev_sof_o, // event: start of frame
   output reg ev_crc_o, // event: crc error
   output reg ev_flow_o // event: underflow or overflow
);

////////////////////////////////////////////////////////////////////////////////
// registers
reg [7:0] ctrl_a_q;
reg [7:0] ctrl_b_q;
reg [7:0] irq_a_q;
reg [7:0] irq_b_q;
reg [7:0] flags_a_q;
reg [1:0] flags_b_q;
reg [3:0] done_ep_q;
reg break_opt_q;
reg hold_pullup_q;
reg upstream_wake_sent_q;
reg resume_seen_q;
reg suspended_q;
reg line_reset_seen_q;
reg [23:0] idle_cnt_q;
reg [23:0] se0_cnt_q;
reg [23:0] drv_cnt_q;
reg driving_q;
reg [1:0] drv_echo_q;
reg [1:0] dp_sync_q;
reg [1:0] dm_sync_q;
reg was_idle_q;

// write address decode, shared by every register write
function wr_hit;
   input [3:0] a;
   input [3:0] ofs;
   begin
      wr_hit = (a == ofs);
   end
endfunction

wire wr_ca = wr_i && wr_hit(addr_i, `OFS_CONTROL_A);
wire wr_cb = wr_i && wr_hit(addr_i, `OFS_CONTROL_B);
wire wr_fa = wr_i && wr_hit(addr_i, `OFS_FLAGS_A);
wire wr_fb = wr_i && wr_hit(addr_i, `OFS_FLAGS_B);
wire enabled = ctrl_a_q[`CA_ENABLE];

////////////////////////////////////////////////////////////////////////////////
// line sampling: two flops before any logic
always @(posedge core_clk_i) begin
   if (rst_i) begin
      dp_sync_q <= 2'h0;
      dm_sync_q <= 2'h0;
   end else begin
      dp_sync_q <= {dp_sync_q[0], dp_i};
      dm_sync_q <= {dm_sync_q[0], dm_i};
   end
end
wire dp_s = dp_sync_q[1];
wire dm_s = dm_sync_q[1];
wire se0 = !dp_s && !dm_s;
// idle (j) state depends on speed: full speed d+ high, low speed d- high
wire line_idle = ctrl_a_q[`CA_SPEED] ? (dp_s && !dm_s) : (!dp_s && dm_s);

// synced lines lag our own drive by two flops; without this mask the
// tail of our own resume would read back as a host resume
always @(posedge core_clk_i) begin
   if (rst_i)
      drv_echo_q <= 2'h0;
   else
      drv_echo_q <= {drv_echo_q[0], driving_q};
end
wire own_drive = driving_q || (drv_echo_q != 2'h0);

////////////////////////////////////////////////////////////////////////////////
// control registers
always @(posedge core_clk_i) begin
   if (rst_i) begin
      ctrl_a_q <= `REG_RESET; // see R15
      ctrl_b_q <= `REG_RESET;
      irq_a_q <= `REG_RESET;
      irq_b_q <= `REG_RESET;
      break_opt_q <= 1'b0;
   end else begin
      if (wr_ca)
         ctrl_a_q <= wdata_i; // see R14
      if (wr_cb)
         ctrl_b_q <= wdata_i & `CB_MASK;
      if (wr_i && wr_hit(addr_i, `OFS_IRQ_CTRL_A))
         irq_a_q <= wdata_i & `IA_MASK;
      if (wr_i && wr_hit(addr_i, `OFS_IRQ_CTRL_B))
         irq_b_q <= wdata_i & `IB_MASK;
      if (wr_i && wr_hit(addr_i, `OFS_DEBUG))
         break_opt_q <= wdata_i[`DB_BREAKOPT];
   end
end

// hold-pullup survives chip reset; only power-on clears it
always @(posedge core_clk_i) begin
   if (por_i)
      hold_pullup_q <= 1'b0; // see R19
   else if (wr_cb)
      hold_pullup_q <= wdata_i[`CB_HOLDPU];
end

////////////////////////////////////////////////////////////////////////////////
// line state: suspend, bus reset, resume
always @(posedge core_clk_i) begin
   if (rst_i || !enabled) begin
      idle_cnt_q <= 24'h0;
      se0_cnt_q <= 24'h0;
      suspended_q <= 1'b0;
      line_reset_seen_q <= 1'b0;
      resume_seen_q <= 1'b0;
      was_idle_q <= 1'b0;
   end else begin
      was_idle_q <= line_idle;
      if (!line_idle)
         idle_cnt_q <= 24'h0;
      else if (idle_cnt_q != IDLE_SUSP_CYC)
         idle_cnt_q <= idle_cnt_q + 24'h1;
      if (line_idle && idle_cnt_q == IDLE_SUSP_CYC - 24'h1)
         suspended_q <= 1'b1; // see R5
      else if (!line_idle && !own_drive)
         suspended_q <= 1'b0;
      if (suspended_q && !line_idle && !own_drive)
         resume_seen_q <= 1'b1; // see R23
      else if (line_idle && idle_cnt_q == IDLE_SUSP_CYC - 24'h1)
         resume_seen_q <= 1'b0;
      if (!se0)
         se0_cnt_q <= 24'h0;
      else if (se0_cnt_q != `SE0_RST_CYC)
         se0_cnt_q <= se0_cnt_q + 24'h1;
      if (se0 && se0_cnt_q == `SE0_RST_CYC - 24'h1)
         line_reset_seen_q <= 1'b1; // see R24
      else if (!se0)
         line_reset_seen_q <= 1'b0;
   end
end
wire susp_rise = line_idle && idle_cnt_q == IDLE_SUSP_CYC - 24'h1 && enabled;
wire rst_rise = se0 && se0_cnt_q == `SE0_RST_CYC - 24'h1 && enabled;
wire resume_ev = suspended_q && !line_idle && !own_drive && enabled;
// wake is combinational from the raw lines so it works with clocks stopped
assign wake_o = suspended_q && !driving_q && (ctrl_a_q[`CA_SPEED] ? !(dp_i && !dm_i)
                                                     : !(!dp_i && dm_i)); // see R6

////////////////////////////////////////////////////////////////////////////////
// remote wake: drive k state once suspended and the idle count reaches WAKE_HOLD_CYC
always @(posedge core_clk_i) begin
   if (rst_i || !enabled) begin
      driving_q <= 1'b0;
      drv_cnt_q <= 24'h0;
      upstream_wake_sent_q <= 1'b0;
   end else if (driving_q) begin
      drv_cnt_q <= drv_cnt_q + 24'h1;
      if (drv_cnt_q == RESUME_DRV_CYC - 24'h1) begin
         driving_q <= 1'b0;
         upstream_wake_sent_q <= 1'b1; // see R23
      end
   end else if (ctrl_b_q[`CB_RWAKE] && suspended_q && idle_cnt_q >= WAKE_HOLD_CYC) begin
      driving_q <= 1'b1; // see R20
      drv_cnt_q <= 24'h0;
   end else if (!suspended_q && line_idle) begin
      upstream_wake_sent_q <= 1'b0;
   end
end
// the idle counter saturates at 3 ms, so with default counts it never reaches the 5 ms wake hold
// k state: opposite of idle
assign dp_o = !ctrl_a_q[`CA_SPEED];
assign dm_o = ctrl_a_q[`CA_SPEED];
assign line_oe_o = driving_q;

////////////////////////////////////////////////////////////////////////////////
// attach and transaction gating
wire attach = ctrl_b_q[`CB_CONNECT] && enabled;
assign dp_pullup_o = (attach || (rst_i && hold_pullup_q)) && ctrl_a_q[`CA_SPEED]; // see R22
assign dm_pullup_o = (attach || (rst_i && hold_pullup_q)) && !ctrl_a_q[`CA_SPEED]; // see R19
assign enabled_o = enabled;
assign full_speed_o = ctrl_a_q[`CA_SPEED]; // see R15
assign done_queue_enable_o = ctrl_a_q[`CA_QUEUE];
assign top_endpoint_index_o = ctrl_a_q[3:0];
assign token_ep_accept_o = enabled && (token_ep_i <= ctrl_a_q[3:0]); // see R18
assign abort_o = !enabled; // see R14
wire break_nack = break_opt_q && debugger_break_ack_o;
assign nack_all_o = (ctrl_b_q[`CB_REFUSE] && !is_setup_i) || break_nack; // see R21
assign mem_block_o = (ctrl_b_q[`CB_REFUSE] && !is_setup_i) || break_nack; // see R13

// debugger break acknowledge
always @(posedge core_clk_i) begin
   if (rst_i)
      debugger_break_ack_o <= 1'b0;
   else if (!debugger_break_i)
      debugger_break_ack_o <= 1'b0;
   else if (!break_opt_q)
      debugger_break_ack_o <= 1'b1; // see R12
   else if (!trans_busy_i)
      debugger_break_ack_o <= 1'b1; // see R13
end

////////////////////////////////////////////////////////////////////////////////
// interrupt flags: set wins over write-one-to-clear
wire [7:0] set_a = enabled ? {sof_i, susp_rise, resume_ev, rst_rise,
                              iso_crc_err_i, starved_i, overrun_i, stall_sent_i}
                           : 8'h00; // see R4 see R7 see R8 see R9 see R10
wire [1:0] set_b = enabled ? {xfer_done_i, setup_done_i} : 2'h0; // see R3
always @(posedge core_clk_i) begin
   if (rst_i) begin
      flags_a_q <= `REG_RESET;
      flags_b_q <= 2'h0;
      done_ep_q <= 4'h0;
   end else begin
      flags_a_q <= (flags_a_q & ~(wr_fa ? wdata_i : 8'h00)) | set_a;
      flags_b_q <= (flags_b_q & ~(wr_fb ? wdata_i[1:0] : 2'h0)) | set_b;
      if (set_b != 2'h0)
         done_ep_q <= done_ep_i; // see R2
   end
end

// completion queue push and frame number store
always @(posedge core_clk_i) begin
   if (rst_i) begin
      queue_push_o <= 1'b0;
      queue_addr_o <= 16'h0000;
      frame_store_o <= 11'h000;
      frame_store_wr_o <= 1'b0;
   end else begin
      queue_push_o <= enabled && ctrl_a_q[`CA_QUEUE] && (xfer_done_i || setup_done_i); // see R16
      if (xfer_done_i || setup_done_i)
         queue_addr_o <= done_table_addr_i; // see R2
      frame_store_wr_o <= enabled && sof_i && ctrl_a_q[`CA_FRSTORE]; // see R17
      if (enabled && sof_i && ctrl_a_q[`CA_FRSTORE])
         frame_store_o <= frame_index_word_i;
   end
end

////////////////////////////////////////////////////////////////////////////////
// vector requests
wire lvl_on = irq_a_q[1:0] != 2'h0; // see R25
wire bus_req = (flags_a_q[`FA_SOF] && irq_a_q[`IA_SOF])
   || (|flags_a_q[`FA_SUSP:`FA_RST] && irq_a_q[`IA_BUSEV])
   || (|flags_a_q[`FA_CRC:`FA_OVF] && irq_a_q[`IA_BUSERR])
   || (flags_a_q[`FA_STALL] && irq_a_q[`IA_STALL]);
assign line_event_vector_o = lvl_on && bus_req; // see R26 see R1
assign xfer_done_vector_o = lvl_on && |(flags_b_q & irq_b_q[1:0]); // see R26 see R1
assign irq_priority_level_o = irq_a_q[1:0];

// events, one-cycle pulses
always @(posedge core_clk_i) begin
   if (rst_i) begin
      ev_setup_o <= 1'b0;
      ev_sof_o <= 1'b0;
      ev_crc_o <= 1'b0;
      ev_flow_o <= 1'b0;
   end else begin
      ev_setup_o <= set_b[`FB_SETUP]; // see R11
      ev_sof_o <= set_a[`FA_SOF];
      ev_crc_o <= set_a[`FA_CRC];
      ev_flow_o <= set_a[`FA_UNF] || set_a[`FA_OVF];
   end
end

////////////////////////////////////////////////////////////////////////////////
// read port
always @(posedge core_clk_i) begin
   if (rst_i)
      rdata_o <= 8'h00;
   else if (rd_i) begin
      case (addr_i)
         `OFS_CONTROL_A: rdata_o <= ctrl_a_q;
         `OFS_CONTROL_B: rdata_o <= {3'h0, hold_pullup_q, ctrl_b_q[3:0]};
         `OFS_LINE_STATUS: rdata_o <= {4'h0, upstream_wake_sent_q, resume_seen_q,
                                       suspended_q, line_reset_seen_q}; // see R23
         `OFS_IRQ_CTRL_A: rdata_o <= irq_a_q;
         `OFS_IRQ_CTRL_B: rdata_o <= irq_b_q;
         `OFS_FLAGS_A: rdata_o <= flags_a_q;
         `OFS_FLAGS_B: rdata_o <= {6'h00, flags_b_q};
         `OFS_FRAME_LO: rdata_o <= frame_store_o[7:0];
         `OFS_FRAME_HI: rdata_o <= {5'h00, frame_store_o[10:8]};
         `OFS_DONE_EP: rdata_o <= {4'h0, done_ep_q};
         `OFS_DEBUG: rdata_o <= {7'h00, break_opt_q};
         default: rdata_o <= 8'h00;
      endcase
   end else
      rdata_o <= 8'h00;
end

endmodule
`default_nettype wire

// >>> usb_ctrl_irq_properties.sv
// concurrent checks on the ports of the usb control and interrupt block
`timescale 1ns/1ps
`default_nettype none
module usb_ctrl_irq_chk (
   input wire core_clk_i, // clock
   input wire rst_i, // sync reset
   input wire rd_i, // read strobe
   input wire [7:0] rdata_o, // read data
   input wire enabled_o, // interface on
   input wire abort_o, // abort now
   input wire full_speed_o, // speed select
   input wire [3:0] top_endpoint_index_o, // highest endpoint
   input wire [3:0] token_ep_i, // token endpoint
   input wire token_ep_accept_o, // token in range
   input wire sof_i, // frame start pulse
   input wire [10:0] frame_index_word_i, // frame number in
   input wire [10:0] frame_store_o, // stored frame number
   input wire frame_store_wr_o, // store pulse
   input wire starved_i, // underflow pulse
   input wire overrun_i, // overflow pulse
   input wire ev_sof_o, // frame start event
   input wire ev_flow_o, // flow event
   input wire dp_pullup_o, // d+ pull-up
   input wire dm_pullup_o, // d- pull-up
   input wire xfer_done_vector_o, // done request
   input wire line_event_vector_o, // bus request
   input wire [1:0] irq_priority_level_o // level
);
   ////////////////////////////////////////////////////////////
   // one clock domain, so clocking and disable are shared
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   // read data only stands in the cycle after a strobe
   a_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data not zero outside read answer");
   a_abort_enable: assert property (abort_o == !enabled_o)
      else $error("abort does not follow enable");
   a_token_range: assert property (token_ep_accept_o ==
      (enabled_o && token_ep_i <= top_endpoint_index_o))
      else $error("token range decision wrong");
   a_sof_event: assert property (enabled_o && sof_i |=> ev_sof_o)
      else $error("frame start event missing");
   a_sof_cause: assert property (ev_sof_o |-> $past(sof_i))
      else $error("frame start event without cause");
   a_flow_event: assert property (enabled_o && (starved_i || overrun_i) |=> ev_flow_o)
      else $error("flow event missing");
   a_frame_saved: assert property (frame_store_wr_o |-> $past(sof_i) &&
      frame_store_o == $past(frame_index_word_i))
      else $error("stored frame number wrong");
   // level zero keeps both vectors quiet
   a_level_gate: assert property (irq_priority_level_o == 2'b00 |->
      !xfer_done_vector_o && !line_event_vector_o)
      else $error("vector raised with level zero");
   a_pullup_speed: assert property (!(dp_pullup_o && !full_speed_o) &&
      !(dm_pullup_o && full_speed_o))
      else $error("pull-up on wrong line for speed");
endmodule
bind usb_ctrl_irq usb_ctrl_irq_chk u_chk (.*);
`default_nettype wire

// >>> usb_host_model.sv
// line model of the upstream host: idle, traffic or bus reset
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
   input wire logic core_clk_i, // clock
   input wire logic [1:0] mode_i, // 0 idle, 1 traffic, 2 reset
   input wire logic full_speed_i, // device speed
   input wire logic dev_dp_i, // device d+ drive
   input wire logic dev_dm_i, // device d- drive
   input wire logic dev_oe_i, // device drives lines
   output logic line_dp_o, // resolved d+
   output logic line_dm_o // resolved d-
);
   logic tog_q = 1'b0;
   ////////////////////////////////////////////////////////////
   // traffic flips j and k each clock so the bus never stays idle two clocks running
   always @(posedge core_clk_i) begin
      tog_q <= ~tog_q;
   end
   // device drive wins the wire; reset is both lines low
   always @* begin
      line_dp_o = full_speed_i ^ (mode_i == 2'd1 && tog_q);
      line_dm_o = !line_dp_o;
      if (mode_i == 2'd2) begin
         line_dp_o = 1'b0;
         line_dm_o = 1'b0;
      end
      if (dev_oe_i) begin
         line_dp_o = dev_dp_i;
         line_dm_o = dev_dm_i;
      end
   end
endmodule
`default_nettype wire

// >>> usb_ctrl_irq_tb_top.sv
// self-checking bench for the usb control and interrupt block
`timescale 1ns/1ps
`default_nettype none
module usb_ctrl_irq_tb_top;
   typedef struct packed {logic [6:0] src; logic [7:0] fa; logic [1:0] fb; logic [3:0] ev;} row_t;
   logic core_clk, rst, por, wr_en, rd_en, busy, is_setup, brk;
   logic [3:0] addr, token_ep, done_ep;
   logic [7:0] wdata;
   logic [6:0] src_q;
   logic [10:0] frame_word;
   logic [15:0] done_addr;
   logic [1:0] mode;
   wire [7:0] rdata;
   wire [10:0] fstore;
   wire [15:0] qaddr;
   wire [3:0] ev;
   wire dp, dm, dpo, dmo, oe, fs, dpu, dmu, acc, fwr, qpush, nack, ack, vx, vl, abrt, mblk;
   int num_errors = 0;
   int num_checks = 0;
   // sources {stall,overrun,starved,crc,setup,xfer,sof}; events {setup,sof,crc,flow}
   row_t rows [7] = '{'{7'h01, 8'h80, 2'h0, 4'h4}, '{7'h02, 8'h00, 2'h2, 4'h0},
      '{7'h04, 8'h00, 2'h1, 4'h8}, '{7'h08, 8'h08, 2'h0, 4'h2}, '{7'h10, 8'h04, 2'h0, 4'h1},
      '{7'h20, 8'h02, 2'h0, 4'h1}, '{7'h40, 8'h01, 2'h0, 4'h0}};
   logic [3:0] ra [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hF};
   logic [7:0] rv [6] = '{8'hFF, 8'h17, 8'h00, 8'hF3, 8'h03, 8'h00};

   usb_ctrl_irq #(.IDLE_SUSP_CYC(24'd40), .WAKE_HOLD_CYC(24'd30), .RESUME_DRV_CYC(24'd10))
   u_usb_ctrl_irq (.core_clk_i(core_clk), .rst_i(rst), .por_i(por), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr_en), .rd_i(rd_en), .rdata_o(rdata), .dp_i(dp), .dm_i(dm),
      .dp_o(dpo), .dm_o(dmo), .line_oe_o(oe), .dp_pullup_o(dpu), .dm_pullup_o(dmu),
      .enabled_o(), .full_speed_o(fs), .done_queue_enable_o(), .top_endpoint_index_o(),
      .token_ep_i(token_ep), .token_ep_accept_o(acc), .sof_i(src_q[0]),
      .frame_index_word_i(frame_word), .frame_store_o(fstore), .frame_store_wr_o(fwr),
      .xfer_done_i(src_q[1]), .setup_done_i(src_q[2]), .done_ep_i(done_ep),
      .done_table_addr_i(done_addr), .queue_push_o(qpush), .queue_addr_o(qaddr),
      .iso_crc_err_i(src_q[3]), .starved_i(src_q[4]), .overrun_i(src_q[5]),
      .stall_sent_i(src_q[6]), .trans_busy_i(busy), .is_setup_i(is_setup), .nack_all_o(nack),
      .mem_block_o(mblk), .abort_o(abrt), .debugger_break_i(brk), .debugger_break_ack_o(ack),
      .xfer_done_vector_o(vx), .line_event_vector_o(vl), .irq_priority_level_o(),
      .wake_o(), .ev_setup_o(ev[3]), .ev_sof_o(ev[2]), .ev_crc_o(ev[1]), .ev_flow_o(ev[0]));
   usb_host_model u_usb_host_model (.core_clk_i(core_clk), .mode_i(mode), .full_speed_i(fs),
      .dev_dp_i(dpo), .dev_dm_i(dmo), .dev_oe_i(oe), .line_dp_o(dp), .line_dm_o(dm));

   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge core_clk);
      wr_en <= 1'b0;
   endtask
   // answer stands only in the cycle after the strobe
   task automatic reg_rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
      @(posedge core_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge core_clk);
      rd_en <= 1'b0;
      #1;
      chk(rdata & m, e);
   endtask
   task automatic pulse(input logic [6:0] s);
      @(posedge core_clk);
      src_q <= s;
      @(posedge core_clk);
      src_q <= 7'h00;
      #1;
   endtask
   task automatic summarize();
      if (num_errors == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // free-running clock at 50 MHz
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // watchdog: the run needs about five hundred cycles
   initial begin
      cyc(20000);
      num_errors++;
      summarize();
   end
   // main sequence
   initial begin
      {addr, wdata, wr_en, rd_en, src_q, token_ep, frame_word} = '0;
      {done_ep, done_addr, busy, is_setup, brk} = '0;
      rst = 1'b1;
      por = 1'b1;
      mode = 2'd1;
      cyc(12);
      rst <= 1'b0;
      por <= 1'b0;
      for (int a = 0; a < 11; a++) reg_rd(a[3:0], 8'h00);
      for (int i = 0; i < 6; i++) begin
         reg_wr(ra[i], 8'hFF);
         reg_rd(ra[i], rv[i]);
      end
      chk({dpu, dmu, nack, mblk}, 4'hB);
      reg_wr(4'h0, 8'h8F);
      @(posedge core_clk) is_setup <= 1'b1;
      #1 chk({dpu, dmu, nack, mblk}, 4'h4);
      @(posedge core_clk) rst <= 1'b1;
      cyc(2);
      #1 chk(dmu, 1'b1);
      @(posedge core_clk) rst <= 1'b0;
      reg_rd(4'h1, 8'h10);
      @(posedge core_clk) por <= 1'b1;
      @(posedge core_clk) por <= 1'b0;
      reg_rd(4'h1, 8'h00);
      // sources with level zero: flags and events, no request
      reg_wr(4'h0, 8'h83);
      reg_wr(4'h3, 8'hF0);
      reg_wr(4'h4, 8'h03);
      for (int i = 0; i < 7; i++) begin
         pulse(rows[i].src);
         chk(ev, rows[i].ev);
         chk({vx, vl}, 2'b00);
         reg_rd(4'h5, rows[i].fa);
         reg_rd(4'h6, {6'h00, rows[i].fb});
         reg_wr(4'h5, 8'hFF);
         reg_wr(4'h6, 8'h03);
      end
      // nonzero level: requests follow enabled flags
      reg_wr(4'h3, 8'hF1);
      pulse(7'h03);
      chk({vx, vl}, 2'b11);
      reg_wr(4'h3, 8'h71);
      reg_wr(4'h4, 8'h00);
      #1 chk({vx, vl}, 2'b00);
      reg_wr(4'h3, 8'hF1);
      reg_wr(4'h4, 8'h03);
      #1 chk({vx, vl}, 2'b11);
      reg_wr(4'h5, 8'hFF);
      reg_wr(4'h6, 8'h03);
      #1 chk({vx, vl}, 2'b00);
      @(posedge core_clk) token_ep <= 4'h3;
      #1 chk(acc, 1'b1);
      @(posedge core_clk) token_ep <= 4'h4;
      #1 chk(acc, 1'b0);
      // frame number store on, then off
      reg_wr(4'h0, 8'h93);
      frame_word <= 11'h5A5;
      pulse(7'h01);
      chk({fwr, fstore}, {1'b1, 11'h5A5});
      reg_rd(4'h7, 8'hA5);
      reg_rd(4'h8, 8'h05);
      reg_wr(4'h0, 8'hA3);
      pulse(7'h01);
      chk(fwr, 1'b0);
      // completion queue on, then off
      @(posedge core_clk) done_ep <= 4'h5;
      done_addr <= 16'h1234;
      pulse(7'h02);
      chk({qpush, qaddr}, {1'b1, 16'h1234});
      reg_rd(4'h9, 8'h05);
      reg_wr(4'h0, 8'h83);
      pulse(7'h02);
      chk(qpush, 1'b0);
      // debugger break without and with the handling option
      @(posedge core_clk) {brk, busy} <= 2'b11;
      cyc(2);
      #1 chk(ack, 1'b1);
      @(posedge core_clk) brk <= 1'b0;
      reg_wr(4'hA, 8'h01);
      brk <= 1'b1;
      cyc(4);
      #1 chk(ack, 1'b0);
      @(posedge core_clk) busy <= 1'b0;
      cyc(2);
      #1 chk({ack, nack, mblk}, 3'h7);
      @(posedge core_clk) brk <= 1'b0;
      reg_wr(4'hA, 8'h00);
      reg_wr(4'h5, 8'hFF);
      // idle into suspend, traffic resumes
      mode <= 2'd0;
      cyc(45);
      reg_rd(4'h2, 8'h02, 8'h02);
      reg_rd(4'h5, 8'h40, 8'h40);
      @(posedge core_clk) mode <= 2'd1;
      cyc(4);
      reg_rd(4'h5, 8'h20, 8'h20);
      // single-ended zero just short of and past the reset time
      @(posedge core_clk) mode <= 2'd2;
      cyc(100);
      reg_rd(4'h2, 8'h00, 8'h01);
      cyc(30);
      reg_rd(4'h2, 8'h01, 8'h01);
      reg_rd(4'h5, 8'h10, 8'h10);
      // remote wake after suspend held long enough
      @(posedge core_clk) mode <= 2'd0;
      cyc(45);
      reg_wr(4'h1, 8'h04);
      for (int i = 0; i < 20 && oe !== 1'b1; i++) cyc(1);
      chk(oe, 1'b1);
      cyc(12);
      reg_rd(4'h2, 8'h08, 8'h08);
      @(posedge core_clk) mode <= 2'd1;
      // disable aborts and ignores events
      reg_wr(4'h0, 8'h00);
      pulse(7'h01);
      chk({abrt, ev}, 5'h10);
      summarize();
   end
endmodule
`default_nettype wire
